// [hdl/mfio_map.svh]
// register offsets, field positions, reset values and timing figures of the io router
`ifndef MFIO_MAP_SVH
`define MFIO_MAP_SVH
`define MFIO_OFF_CTRL     12'h000
`define MFIO_OFF_GPOUT    12'h004
`define MFIO_OFF_GPIN     12'h008
`define MFIO_OFF_STATUS   12'h00C
`define MFIO_OFF_SWSTART  12'h010
`define MFIO_CTRL_RST     14'h0000
`define MFIO_GPOUT_RST    5'h00
`define MFIO_CTRL_W       14
`define MFIO_SWSTART_BIT  0
`define MFIO_CLK_PERIOD_NS 25
`define MFIO_EXT_TRIG_NS  200
`define MFIO_INT_TRIG_NS  1000
`define MFIO_TRIG_PIPE    4
`endif

// [hdl/mfio_pkg.sv]
// types shared by the multi-function io router
package mfio_pkg;
    typedef enum logic [1:0] {
        MFIO_GRP_CTR_ACQ = 2'b00,
        MFIO_GRP_EXPAND  = 2'b01,
        MFIO_GRP_GPIO    = 2'b10,
        MFIO_GRP_NONE    = 2'b11
    } mfio_grp_e;
    typedef enum logic [2:0] {
        MFIO_B5_TRIG_OUT = 3'b000,
        MFIO_B5_PACER    = 3'b001,
        MFIO_B5_CTR0     = 3'b010,
        MFIO_B5_CTR1     = 3'b011,
        MFIO_B5_CTR2     = 3'b100,
        MFIO_B5_NONE     = 3'b111
    } mfio_b5_e;
    // control register layout, lsb last
    typedef struct packed {
        logic      trig_falling;
        logic      about_trig;
        logic      ctr1_ext_gate;
        logic      ctr0_ext_gate;
        logic      ctr1_ext_clk;
        logic      ctr0_ext_clk;
        logic      trig_is_gate;
        logic      ext_trig_en;
        logic      ext_pacer;
        mfio_b5_e  b5_sel;
        mfio_grp_e grp;
    } mfio_ctrl_s;
    // signals coming from the board's own acquisition and counter logic
    typedef struct packed {
        logic       int_pacer;
        logic       int_trig;
        logic       acq_stop;
        logic       scan_done;
        logic [2:0] ctr_out;
        logic [2:0] int_ctr_clk;
        logic [1:0] int_ctr_gate;
        logic [3:0] exp_addr;
        logic       exp_gain;
    } mfio_core_s;
endpackage

// [hdl/mfio_router.sv]
// multi-function digital io router with apb configuration registers
//
// Summary of operation
// - input bit zero can be external pacer clock
// - exactly one pacer source times conversions
// - software start accepted alongside hardware pacer
// - input bit one can be trigger or gate
// - input bits two, three clock counters zero, one
// - counter two clocked only internally
// - input bits four, five gate counters zero, one
// - counter two has no external gate
// - trigger-out follows active trigger and gate
// - external trigger edge to trigger-out about 200ns
// - external gate edge to trigger-out about 200ns
// - internal trigger to trigger-out under 1us
// - no trigger-out during about-trigger acquisitions
// - output bit five selected apart from group
// - pacer output follows selected pacer clock
// - option 0 puts pacer on output bit four
// - frame sync goes low after each scan
// - option 0 puts counters on output bits one to three
// - option 0 shows all counters; bit five any
// - option 1 puts expansion address on bits 0-3
// - option 1 puts gain bit on bit four
// - inputs always readable without disturbing functions
// - one group option at a time for bits 0-4
// - one option makes bits 0-4 software outputs
`timescale 1ns/1ps
`include "mfio_map.svh"

module mfio_router
    import mfio_pkg::*;
#(
    parameter int unsigned CLK_PERIOD_NS = `MFIO_CLK_PERIOD_NS
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // multi-function input pins
    input  wire logic        mf_in_bit_zero,
    input  wire logic        mf_in_bit_one,
    input  wire logic        mf_in_bit_two,
    input  wire logic        mf_in_bit_three,
    input  wire logic        mf_in_bit_four,
    input  wire logic        mf_in_bit_five,
    // multi-function output pins
    output logic             mf_out_bit_zero,
    output logic             mf_out_bit_one,
    output logic             mf_out_bit_two,
    output logic             mf_out_bit_three,
    output logic             mf_out_bit_four,
    output logic             mf_out_bit_five,
    // board acquisition and counter logic, same clock
    input  mfio_core_s       core,
    output logic             conv_pacer,
    output logic             conv_start,
    output logic             acq_trig,
    output logic [2:0]       ctr_clk,
    output logic [2:0]       ctr_gate
);

    // trigger delay figures in cycles; the pin sync path eats part of it
    localparam int unsigned EXT_DLY_CYC =
        (`MFIO_EXT_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned INT_MAX_CYC = `MFIO_INT_TRIG_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  EXT_LOAD =
        4'(EXT_DLY_CYC - `MFIO_TRIG_PIPE);

    // state
    mfio_ctrl_s ctrl_q;
    logic [4:0] gpout_q;
    logic [5:0] sync1_q;
    logic [5:0] sync2_q;
    logic       pace_prev_q;
    logic       trig_prev_q;
    logic       int_prev_q;
    logic [3:0] dly_cnt_q;
    logic       dly_busy_q;
    logic       trig_out_q;
    logic       frame_q;
    logic       sw_start_q;
    logic [5:0] out_q;
    logic       conv_pacer_q;
    logic       conv_start_q;
    logic       acq_trig_q;
    logic [2:0] ctr_clk_q;
    logic [2:0] ctr_gate_q;
    logic [31:0] prdata_q;
    logic       pready_q;
    logic       pslverr_q;

    // raw pins gathered for the synchroniser
    logic [5:0] pins;
    assign pins = {mf_in_bit_five, mf_in_bit_four, mf_in_bit_three,
                   mf_in_bit_two, mf_in_bit_one, mf_in_bit_zero};

    // two-flop synchroniser; only sync2 feeds any logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
        end else begin
            sync1_q <= pins;
            sync2_q <= sync1_q;
        end
    end

    // apb decode
    wire        acc      = psel & penable & ~pready_q;
    wire        wr       = acc & pwrite;
    wire        hit_ctrl = (paddr == `MFIO_OFF_CTRL);
    wire        hit_gpo  = (paddr == `MFIO_OFF_GPOUT);
    wire        hit_gpi  = (paddr == `MFIO_OFF_GPIN);
    wire        hit_sts  = (paddr == `MFIO_OFF_STATUS);
    wire        hit_sws  = (paddr == `MFIO_OFF_SWSTART);
    wire        hit_any  = hit_ctrl | hit_gpo | hit_gpi | hit_sts | hit_sws;
    wire [31:0] sts_word = {24'h00_0000, acq_trig_q, conv_pacer_q,
                            dly_busy_q, frame_q, trig_out_q, ctr_gate_q[1:0],
                            ctr_clk_q[0]};
    wire [31:0] rd_word  =
        hit_ctrl ? {18'h0_0000, ctrl_q} :
        hit_gpo  ? {27'h000_0000, gpout_q} :
        hit_gpi  ? {26'h000_0000, sync2_q} :
        hit_sts  ? sts_word : 32'h0000_0000;

    // one wait state so read data comes out of a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= acc;
            pslverr_q <= acc & ~hit_any;
            prdata_q  <= (acc & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= mfio_ctrl_s'(`MFIO_CTRL_RST);
            gpout_q    <= `MFIO_GPOUT_RST;
            sw_start_q <= 1'b0;
        end else begin
            if (wr & hit_ctrl)
                ctrl_q <= mfio_ctrl_s'(pwdata[`MFIO_CTRL_W-1:0]);
            if (wr & hit_gpo)
                gpout_q <= pwdata[4:0];
            sw_start_q <= wr & hit_sws & pwdata[`MFIO_SWSTART_BIT];
        end
    end

    // pacer selection: one mux, so both sources can never drive at once
    wire pace_sel  = ctrl_q.ext_pacer ? sync2_q[0] : core.int_pacer;
    wire pace_rise = pace_sel & ~pace_prev_q;

    // external trigger or gate on input bit one, chosen edge is active
    wire ext_lvl   = sync2_q[1] ^ ctrl_q.trig_falling;
    wire ext_edge  = ctrl_q.ext_trig_en & ext_lvl & ~trig_prev_q;
    wire ext_end   = ctrl_q.ext_trig_en & ~ext_lvl & trig_prev_q;
    wire int_edge  = ~ctrl_q.ext_trig_en & core.int_trig & ~int_prev_q;
    wire int_end   = ~ctrl_q.ext_trig_en & ~core.int_trig & int_prev_q;
    wire act_lvl   = ctrl_q.ext_trig_en ? ext_lvl : core.int_trig;
    // a gate ends when it drops, a trigger ends at acquisition stop
    wire trig_end  = ctrl_q.trig_is_gate ? (ext_end | int_end) : core.acq_stop;
    wire dly_done  = dly_busy_q & (dly_cnt_q == 4'h0);

    // edge history and conversion pacing
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pace_prev_q  <= 1'b0;
            trig_prev_q  <= 1'b0;
            int_prev_q   <= 1'b0;
            conv_pacer_q <= 1'b0;
            conv_start_q <= 1'b0;
            acq_trig_q   <= 1'b0;
        end else begin
            pace_prev_q  <= pace_sel;
            trig_prev_q  <= ext_lvl;
            int_prev_q   <= core.int_trig;
            conv_pacer_q <= pace_sel;
            conv_start_q <= pace_rise | sw_start_q;
            acq_trig_q   <= act_lvl;
        end
    end

    // external starts wait out the documented delay before trigger-out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_cnt_q  <= 4'h0;
            dly_busy_q <= 1'b0;
        end else if (ext_edge) begin
            dly_cnt_q  <= EXT_LOAD;
            dly_busy_q <= 1'b1;
        end else if (dly_done | trig_end) begin
            dly_busy_q <= 1'b0;
        end else if (dly_busy_q) begin
            dly_cnt_q  <= dly_cnt_q - 4'h1;
        end
    end

    // trigger-out; internal edges raise it at once, far under the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            trig_out_q <= 1'b0;
        else if (ctrl_q.about_trig)
            trig_out_q <= 1'b0;
        else if (dly_done | int_edge)
            trig_out_q <= 1'b1;
        else if (trig_end)
            trig_out_q <= 1'b0;
    end

    // frame sync idles high and drops for the cycle after a scan ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            frame_q <= 1'b1;
        else
            frame_q <= ~core.scan_done;
    end

    // counter clock and gate routing for counters zero and one
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_ctr
            wire clk_ext  = gi ? ctrl_q.ctr1_ext_clk : ctrl_q.ctr0_ext_clk;
            wire gate_ext = gi ? ctrl_q.ctr1_ext_gate : ctrl_q.ctr0_ext_gate;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctr_clk_q[gi]  <= 1'b0;
                    ctr_gate_q[gi] <= 1'b1;
                end else begin
                    ctr_clk_q[gi]  <= clk_ext ? sync2_q[2+gi]
                                              : core.int_ctr_clk[gi];
                    ctr_gate_q[gi] <= gate_ext ? sync2_q[4+gi]
                                               : core.int_ctr_gate[gi];
                end
            end
        end
    endgenerate

    // counter two: internal clock only, gate held enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctr_clk_q[2]  <= 1'b0;
            ctr_gate_q[2] <= 1'b1;
        end else begin
            ctr_clk_q[2]  <= core.int_ctr_clk[2];
            ctr_gate_q[2] <= 1'b1;
        end
    end

    // group option for bits zero to four; one case arm, never mixed
    logic [4:0] grp_bits;
    always_comb begin
        case (ctrl_q.grp)
            MFIO_GRP_CTR_ACQ:
                grp_bits = {pace_sel, core.ctr_out, frame_q};
            MFIO_GRP_EXPAND:
                grp_bits = {core.exp_gain, core.exp_addr};
            MFIO_GRP_GPIO:
                grp_bits = gpout_q;
            default:
                grp_bits = 5'h00;
        endcase
    end

    // bit five source, independent of the group option
    logic b5_bit;
    always_comb begin
        case (ctrl_q.b5_sel)
            MFIO_B5_TRIG_OUT: b5_bit = trig_out_q;
            MFIO_B5_PACER:    b5_bit = pace_sel;
            MFIO_B5_CTR0:     b5_bit = core.ctr_out[0];
            MFIO_B5_CTR1:     b5_bit = core.ctr_out[1];
            MFIO_B5_CTR2:     b5_bit = core.ctr_out[2];
            default:          b5_bit = 1'b0;
        endcase
    end

    // output pin register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            out_q <= 6'h00;
        else
            out_q <= {b5_bit, grp_bits};
    end

    // ports straight from flops
    assign mf_out_bit_zero  = out_q[0];
    assign mf_out_bit_one   = out_q[1];
    assign mf_out_bit_two   = out_q[2];
    assign mf_out_bit_three = out_q[3];
    assign mf_out_bit_four  = out_q[4];
    assign mf_out_bit_five  = out_q[5];
    assign conv_pacer       = conv_pacer_q;
    assign conv_start       = conv_start_q;
    assign acq_trig         = acq_trig_q;
    assign ctr_clk          = ctr_clk_q;
    assign ctr_gate         = ctr_gate_q;
    assign prdata           = prdata_q;
    assign pready           = pready_q;
    assign pslverr          = pslverr_q;

endmodule

// [tb/mfio_router_props.sv]
// port-level assertions for the multi-function io router
`timescale 1ns/1ps
`include "mfio_map.svh"

module mfio_router_props
    import mfio_pkg::*;
(
    // clock, reset and apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and board side
    input wire logic        mf_in_bit_one,
    input wire logic        mf_out_bit_one,
    input wire logic        mf_out_bit_two,
    input wire logic        mf_out_bit_three,
    input wire logic        mf_out_bit_five,
    input wire mfio_core_s  core,
    input wire logic        conv_start,
    input wire logic [2:0]  ctr_clk,
    input wire logic [2:0]  ctr_gate
);
    logic [13:0] sh_q;
    logic [1:0]  up_q;
    wire         take = psel && penable && !pready;
    wire         up   = (up_q == 2'h3);

    // shadow of the control word; up_q masks the edges whose past still sees reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q <= 14'h0000;
            up_q <= 2'h0;
        end else begin
            if (take && pwrite && paddr == `MFIO_OFF_CTRL)
                sh_q <= pwdata[13:0];
            if (up_q != 2'h3)
                up_q <= up_q + 2'h1;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_ready_one_wait: assert property (take |=> pready && !take)
        else $error("no answer one cycle after access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held past one cycle");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr outside an answer");
    a_ctr2_gate_high: assert property (up |-> ctr_gate[2])
        else $error("counter two gate not held enabled");
    a_ctr2_clk_int: assert property (up && $stable(core.int_ctr_clk[2])
        |-> ctr_clk[2] == core.int_ctr_clk[2])
        else $error("counter two clock not internal");
    a_swstart_conv: assert property (take && pwrite && paddr == `MFIO_OFF_SWSTART
        && pwdata[0] |-> ##[1:3] conv_start)
        else $error("software start not passed on");
    a_ctr_out_route: assert property (up && sh_q[1:0] == 2'h0 && $past(sh_q[1:0]) == 2'h0
        && $stable(core.ctr_out)
        |-> {mf_out_bit_three, mf_out_bit_two, mf_out_bit_one} == core.ctr_out)
        else $error("counter outputs misrouted");
    a_trig_out_delay: assert property (up && $rose(mf_in_bit_one) && sh_q[6]
        && sh_q[4:2] == 3'h0 && sh_q[13:12] == 2'h0 |-> ##[7:11] mf_out_bit_five)
        else $error("trigger-out late after input edge");
    a_about_quiet: assert property (up && sh_q[12] && $past(sh_q[12], 3)
        && sh_q[4:2] == 3'h0 |-> !mf_out_bit_five)
        else $error("trigger-out during about-trigger");
endmodule

bind mfio_router mfio_router_props u_props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .mf_in_bit_one(mf_in_bit_one), .mf_out_bit_one(mf_out_bit_one),
    .mf_out_bit_two(mf_out_bit_two), .mf_out_bit_three(mf_out_bit_three),
    .mf_out_bit_five(mf_out_bit_five), .core(core), .conv_start(conv_start),
    .ctr_clk(ctr_clk), .ctr_gate(ctr_gate)
);

// [tb/mfio_ext_pins.sv]
// external ttl sources driving the six multi-function input pins
`timescale 1ns/1ps

module mfio_ext_pins (
    // board clock, only to pace the sources
    input  wire logic       pclk,
    // levels asked for and pins as the board sees them
    input  wire logic [5:0] want,
    output logic      [5:0] pins
);
    // half a cycle off the board edge, as an unrelated instrument would be
    always_ff @(negedge pclk) begin
        pins <= want;
    end
endmodule

// [tb/mfio_router_tb_top.sv]
// self-checking bench for the multi-function io router
`timescale 1ns/1ps
`include "mfio_map.svh"

module mfio_router_tb_top
    import mfio_pkg::*;
;
    logic        pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, conv_pacer, conv_start, acq_trig;
    logic [2:0]  ctr_clk, ctr_gate;
    logic [5:0]  want, pins;
    wire  [5:0]  outs;
    mfio_core_s  core;
    int          mismatches, total_checks, cyc, starts;

    mfio_router dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mf_in_bit_zero(pins[0]), .mf_in_bit_one(pins[1]), .mf_in_bit_two(pins[2]),
        .mf_in_bit_three(pins[3]), .mf_in_bit_four(pins[4]), .mf_in_bit_five(pins[5]),
        .mf_out_bit_zero(outs[0]), .mf_out_bit_one(outs[1]), .mf_out_bit_two(outs[2]),
        .mf_out_bit_three(outs[3]), .mf_out_bit_four(outs[4]), .mf_out_bit_five(outs[5]),
        .core(core), .conv_pacer(conv_pacer), .conv_start(conv_start),
        .acq_trig(acq_trig), .ctr_clk(ctr_clk), .ctr_gate(ctr_gate)
    );
    mfio_ext_pins u_pins (.pclk(pclk), .want(want), .pins(pins));

    // 40 MHz board clock
    initial pclk = 1'h0;
    always #12.5 pclk = ~pclk;

    // hang guard
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            print_verdict();
        end
    end
    // start pulses tallied mid-cycle, where they have settled
    always @(negedge pclk) begin
        if (conv_start === 1'h1) starts++;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; answer taken at the rising edge that sees pready high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // idle edge so the next call never rewrites psel in this time step
        @(posedge pclk);
    endtask
    task automatic cfg(input logic [13:0] c);
        xfer(1'h1, `MFIO_OFF_CTRL, {18'h00000, c});
        repeat (3) @(posedge pclk);
    endtask
    // cycles until an output bit reaches a level, bounded
    task automatic wait_out(input int i, input logic v, output int n);
        n = 0;
        while (outs[i] !== v && n < 60) begin
            @(negedge pclk);
            n++;
        end
        @(posedge pclk);
    endtask
    task automatic pulse_stop();
        core.acq_stop <= 1'h1;
        @(posedge pclk);
        core.acq_stop <= 1'h0;
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        int n;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        core = '0;
        want = 6'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        // reset values, software outputs, unmapped place
        xfer(1'h0, `MFIO_OFF_CTRL, 32'h0); chk(rd, `MFIO_CTRL_RST);
        xfer(1'h1, `MFIO_OFF_GPOUT, 32'h15);
        xfer(1'h0, `MFIO_OFF_GPOUT, 32'h0); chk(rd, 32'h15);
        xfer(1'h0, 12'h020, 32'h0); chk({rd[30:0], err}, 32'h1);
        cfg(14'h0002); chk(outs[4:0], 5'h15);
        // counter group, bit five through every selector code
        core.ctr_out <= 3'h3;
        core.int_pacer <= 1'h1;
        for (int i = 0; i < 8; i++) begin
            cfg({9'h000, i[2:0], 2'h0});
            chk(outs, {8'h0E >> i & 8'h1, 1'h1, 3'h3, 1'h1});
        end
        // frame sync dips once per finished scan
        core.scan_done <= 1'h1;
        @(posedge pclk);
        core.scan_done <= 1'h0;
        wait_out(0, 1'h0, n); chk(n < 5, 1);
        wait_out(0, 1'h1, n); chk(n < 5, 1);
        // expansion group, then the unused code
        core.exp_addr <= 4'hA;
        core.exp_gain <= 1'h1;
        cfg(14'h0001); chk(outs, 6'h1A);
        cfg(14'h0003); chk(outs[4:0], 5'h00);
        // pins routed to counters stay readable
        want <= 6'h25;
        core.int_ctr_clk <= 3'h4;
        cfg(14'h0F00);
        xfer(1'h0, `MFIO_OFF_GPIN, 32'h0); chk(rd, 32'h25);
        chk({ctr_gate, ctr_clk}, 6'h35);
        // external pacer replaces the internal one
        core.int_pacer <= 1'h0;
        cfg(14'h0024); chk({conv_pacer, outs[5:4]}, 3'h7);
        core.int_pacer <= 1'h1;
        want <= 6'h24;
        repeat (6) @(posedge pclk);
        chk({conv_pacer, outs[5:4]}, 3'h0);
        n = starts;
        xfer(1'h1, `MFIO_OFF_SWSTART, 32'h1);
        repeat (3) @(posedge pclk);
        chk(starts - n, 1);
        // external trigger, then gate, on input bit one
        want <= 6'h00;
        cfg(14'h0040);
        want <= 6'h02;
        wait_out(5, 1'h1, n); chk(n inside {[8:12]}, 1);
        chk(acq_trig, 1'h1);
        pulse_stop();
        wait_out(5, 1'h0, n); chk(n < 5, 1);
        want <= 6'h00;
        cfg(14'h00C0);
        want <= 6'h02;
        wait_out(5, 1'h1, n); chk(n inside {[8:12]}, 1);
        want <= 6'h00;
        wait_out(5, 1'h0, n); chk(n < 12, 1);
        // internal trigger, then the about-trigger lockout
        cfg(14'h0000);
        core.int_trig <= 1'h1;
        wait_out(5, 1'h1, n); chk(n < 40, 1);
        core.int_trig <= 1'h0;
        pulse_stop();
        cfg(14'h1000);
        core.int_trig <= 1'h1;
        repeat (8) @(posedge pclk);
        chk(outs[5], 1'h0);
        print_verdict();
    end
endmodule
